// ---- design/tcx_evt_gen.sv ----
// drives one falling edge on the count input per request
// assumes requests arrive only while busy is low
module tcx_evt_gen (
    input wire logic ref_clk,
    input wire logic arst_n,
    tcx_evt_if.gen evt,
    output logic event_count_input
);
    typedef enum logic [2:0] {
        TCX_EG_IDLE = 3'b001,
        TCX_EG_LOW = 3'b010,
        TCX_EG_HIGH = 3'b100
    } tcx_eg_state_t;

    tcx_eg_state_t state_r, state_nxt;
    logic [6:0] cnt_r, cnt_nxt;
    logic out_r, out_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        case (state_r)
            TCX_EG_IDLE: begin
                if (evt.fire) begin
                    state_nxt = TCX_EG_LOW;
                    cnt_nxt = '0;
                    out_nxt = 1'b0;
                end
            end
            TCX_EG_LOW: begin
                cnt_nxt = cnt_r + 7'h01;
                if (cnt_r == tcx_pkg::TCX_EVT_PHASE_LAST) begin
                    state_nxt = TCX_EG_HIGH;
                    cnt_nxt = '0;
                    out_nxt = 1'b1;
                end
            end
            TCX_EG_HIGH: begin
                cnt_nxt = cnt_r + 7'h01;
                if (cnt_r == tcx_pkg::TCX_EVT_PHASE_LAST) begin
                    state_nxt = TCX_EG_IDLE;
                    cnt_nxt = '0;
                end
            end
            default: begin
                state_nxt = TCX_EG_IDLE;
                cnt_nxt = '0;
                out_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= TCX_EG_IDLE;
            cnt_r <= 7'h00;
            out_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign event_count_input = out_r;
    assign evt.busy = (state_r != TCX_EG_IDLE);

    // helper: cycles since the pin last changed, saturating
    logic [7:0] hold_r;
    logic prev_r;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_r <= 8'hFF;
            prev_r <= 1'b1;
        end else begin
            prev_r <= out_r;
            hold_r <= (out_r != prev_r) ? 8'h01 : ((hold_r == 8'hFF) ? hold_r : hold_r + 8'h01);
        end
    end

    property p_evt_phase;
        @(posedge ref_clk) disable iff (!arst_n)
        (out_r != prev_r) |-> (hold_r >= 8'(tcx_pkg::TCX_EVT_PHASE_CYC));
    endproperty
    a_evt_phase: assert property (p_evt_phase) else $error("count input phase too short");
endmodule

// ---- design/tcx_evt_if.sv ----
// request path from the sequencer to the event pulser
// assumes both ends share ref_clk
interface tcx_evt_if;
    logic fire;
    logic busy;
    modport ctl (output fire, input busy);
    modport gen (input fire, output busy);
endinterface

// ---- design/tcx_host.sv ----
// host controller that programs the cascaded 16-bit timer over its byte port
// assumes a one-cycle write strobe latches dev_addr/dev_wdata in the device
// Notes on behaviour
// - period written low byte then high
// - period changed only while counter stopped
// - preset kept zero in timer/event modes
// - count input phases last two machine cycles
// - duty written low byte then high
// - duty rewritten right after interrupt
// - stop first, preset in separate write
// - force high: stop, then clear preset
// - stop timer before deep stop
// - port latch set for pwm pin
module tcx_host (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_op,
    input wire logic [15:0] cmd_data,
    input wire logic slow_mode,
    output logic irq_event,
    output logic pwm_level,
    output logic [2:0] dev_addr,
    output logic [7:0] dev_wdata,
    output logic dev_wr,
    output logic divider7_clock_select,
    output logic port_latch,
    output logic event_count_input,
    input wire logic match_overflow_irq,
    input wire logic pwm_out_pin
);
    typedef enum logic [7:0] {
        TCX_S_IDLE = 8'b00000001,
        TCX_S_STOP = 8'b00000010,
        TCX_S_WLO = 8'b00000100,
        TCX_S_WHI = 8'b00001000,
        TCX_S_CFG = 8'b00010000,
        TCX_S_CTL = 8'b00100000,
        TCX_S_PRE = 8'b01000000,
        TCX_S_WAIT = 8'b10000000
    } tcx_state_t;

    tcx_evt_if evt ();

    tcx_evt_gen u_evt (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .evt(evt.gen),
        .event_count_input(event_count_input)
    );

    // pin synchroniser: irq at bit 0, pwm pin at bit 1
    logic [1:0] s1_r, s2_r, s3_r, stab_r, stab_nxt;
    always_comb begin
        stab_nxt = stab_r;
        for (int i = 0; i < 2; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                stab_nxt[i] = s3_r[i];
            end
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            s3_r <= 2'h0;
            stab_r <= 2'h0;
        end else begin
            s1_r <= {pwm_out_pin, match_overflow_irq};
            s2_r <= s1_r;
            s3_r <= s2_r;
            stab_r <= stab_nxt;
        end
    end
    logic irq_rise;
    assign irq_rise = stab_nxt[0] & ~stab_r[0];
    assign irq_event = irq_rise;
    assign pwm_level = stab_r[1];

    function automatic logic [7:0] ctl_high(input logic pre, input logic run, input logic [1:0] md);
        logic [7:0] v;
        v = tcx_pkg::TCX_CTRL_RESET;
        v[tcx_pkg::TCX_PRESET_BIT] = pre;
        v[tcx_pkg::TCX_RUN_BIT] = run;
        v[1:0] = md;
        return v;
    endfunction

    // slow modes keep only the low-rate sources
    function automatic logic [2:0] legal_clk(input logic [2:0] c, input logic [1:0] md, input logic slow);
        logic pwm;
        pwm = (md == tcx_pkg::TCX_MODE_PWM);
        if (slow) begin
            return (pwm && c == tcx_pkg::TCX_CLK_FS) ? c : tcx_pkg::TCX_CLK_SLOWEST;
        end
        if (!pwm && c > tcx_pkg::TCX_CLK_DIV3) begin
            return tcx_pkg::TCX_CLK_SLOWEST;
        end
        return (c > tcx_pkg::TCX_CLK_FC) ? tcx_pkg::TCX_CLK_SLOWEST : c;
    endfunction

    tcx_state_t state_r, state_nxt;
    logic [2:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic wr_r, wr_nxt;
    logic run_r, run_nxt, pre_r, pre_nxt, restart_r, restart_nxt, duty_r, duty_nxt, div7_r, div7_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [2:0] clk_r, clk_nxt;
    logic [15:0] word_r, word_nxt;
    logic is_pwm;
    assign is_pwm = (mode_r == tcx_pkg::TCX_MODE_PWM);

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        wr_nxt = 1'b0;
        run_nxt = run_r;
        pre_nxt = pre_r;
        restart_nxt = restart_r;
        duty_nxt = duty_r;
        div7_nxt = div7_r;
        mode_nxt = mode_r;
        clk_nxt = clk_r;
        word_nxt = word_r;
        evt.fire = 1'b0;
        case (state_r)
            TCX_S_IDLE: begin
                if (cmd_valid && cmd_ready) begin
                    case (cmd_op)
                        tcx_pkg::TCX_OP_CONFIG: begin
                            // mode and source for the cascaded pair
                            mode_nxt = cmd_data[1:0];
                            clk_nxt = legal_clk(cmd_data[4:2], cmd_data[1:0], slow_mode);
                            div7_nxt = cmd_data[6] | slow_mode;
                            pre_nxt = (cmd_data[1:0] == tcx_pkg::TCX_MODE_PWM) ? cmd_data[5] : 1'b0;
                            run_nxt = 1'b0;
                            state_nxt = TCX_S_CFG;
                        end
                        tcx_pkg::TCX_OP_PERIOD, tcx_pkg::TCX_OP_DUTY: begin
                            word_nxt = cmd_data;
                            duty_nxt = (cmd_op == tcx_pkg::TCX_OP_DUTY);
                            restart_nxt = 1'b0;
                            if (cmd_op == tcx_pkg::TCX_OP_DUTY && run_r && is_pwm) begin
                                state_nxt = TCX_S_WAIT;
                            end else if (cmd_op == tcx_pkg::TCX_OP_PERIOD && run_r) begin
                                restart_nxt = 1'b1;
                                state_nxt = TCX_S_STOP;
                            end else begin
                                state_nxt = TCX_S_WLO;
                            end
                        end
                        tcx_pkg::TCX_OP_START, tcx_pkg::TCX_OP_STOP: begin
                            // start bit begins match counting; stop
                            run_nxt = (cmd_op == tcx_pkg::TCX_OP_START);
                            state_nxt = TCX_S_CTL;
                        end
                        tcx_pkg::TCX_OP_LEVEL: begin
                            // polarity via preset; zero outside pwm
                            word_nxt = {15'h0000, cmd_data[0] & is_pwm};
                            restart_nxt = 1'b0;
                            state_nxt = run_r ? TCX_S_STOP : TCX_S_PRE;
                        end
                        tcx_pkg::TCX_OP_PULSE: begin
                            evt.fire = 1'b1;
                        end
                        default: begin
                            state_nxt = TCX_S_IDLE;
                        end
                    endcase
                end
            end
            TCX_S_STOP: begin
                wr_nxt = 1'b1;
                addr_nxt = tcx_pkg::TCX_ADDR_CTRL_HIGH;
                wdata_nxt = ctl_high(pre_r, 1'b0, mode_r);
                run_nxt = 1'b0;
                state_nxt = restart_r ? TCX_S_WLO : TCX_S_PRE;
            end
            TCX_S_WLO: begin
                wr_nxt = 1'b1;
                addr_nxt = duty_r ? tcx_pkg::TCX_ADDR_DUTY_LO : tcx_pkg::TCX_ADDR_PERIOD_LO;
                wdata_nxt = word_r[7:0];
                state_nxt = TCX_S_WHI;
            end
            TCX_S_WHI: begin
                wr_nxt = 1'b1;
                addr_nxt = duty_r ? tcx_pkg::TCX_ADDR_DUTY_HI : tcx_pkg::TCX_ADDR_PERIOD_HI;
                wdata_nxt = word_r[15:8];
                if (restart_r) begin
                    run_nxt = 1'b1;
                    restart_nxt = 1'b0;
                    state_nxt = TCX_S_CTL;
                end else begin
                    state_nxt = TCX_S_IDLE;
                end
            end
            TCX_S_CFG: begin
                wr_nxt = 1'b1;
                addr_nxt = tcx_pkg::TCX_ADDR_CTRL_LOW;
                wdata_nxt = {1'b0, clk_r, 2'b00, mode_r};
                state_nxt = TCX_S_CTL;
            end
            TCX_S_CTL: begin
                wr_nxt = 1'b1;
                addr_nxt = tcx_pkg::TCX_ADDR_CTRL_HIGH;
                wdata_nxt = ctl_high(pre_r, run_r, mode_r);
                state_nxt = TCX_S_IDLE;
            end
            TCX_S_PRE: begin
                wr_nxt = 1'b1;
                addr_nxt = tcx_pkg::TCX_ADDR_CTRL_HIGH;
                wdata_nxt = ctl_high(word_r[0], 1'b0, mode_r);
                pre_nxt = word_r[0];
                state_nxt = TCX_S_IDLE;
            end
            TCX_S_WAIT: begin
                // device shifts the buffer at this interrupt
                if (irq_rise) begin
                    state_nxt = TCX_S_WLO;
                end
            end
            default: begin
                state_nxt = TCX_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= TCX_S_IDLE;
            addr_r <= 3'h0;
            wdata_r <= 8'h00;
            wr_r <= 1'b0;
            run_r <= 1'b0;
            pre_r <= 1'b0;
            restart_r <= 1'b0;
            duty_r <= 1'b0;
            div7_r <= 1'b0;
            mode_r <= tcx_pkg::TCX_MODE_TIMER;
            clk_r <= tcx_pkg::TCX_CLK_SLOWEST;
            word_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            wr_r <= wr_nxt;
            run_r <= run_nxt;
            pre_r <= pre_nxt;
            restart_r <= restart_nxt;
            duty_r <= duty_nxt;
            div7_r <= div7_nxt;
            mode_r <= mode_nxt;
            clk_r <= clk_nxt;
            word_r <= word_nxt;
        end
    end

    assign cmd_ready = (state_r == TCX_S_IDLE) && !evt.busy;
    assign dev_addr = addr_r;
    assign dev_wdata = wdata_r;
    assign dev_wr = wr_r;
    assign divider7_clock_select = div7_r;
    // latch high whenever pwm is selected
    assign port_latch = is_pwm;

    property p_period_pair;
        @(posedge ref_clk) disable iff (!arst_n)
        (dev_wr && dev_addr == tcx_pkg::TCX_ADDR_PERIOD_LO) |=> (dev_wr && dev_addr == tcx_pkg::TCX_ADDR_PERIOD_HI);
    endproperty
    a_period_pair: assert property (p_period_pair) else $error("period high byte missing");

    property p_duty_pair;
        @(posedge ref_clk) disable iff (!arst_n)
        (dev_wr && dev_addr == tcx_pkg::TCX_ADDR_DUTY_HI) |-> $past(dev_wr && dev_addr == tcx_pkg::TCX_ADDR_DUTY_LO);
    endproperty
    a_duty_pair: assert property (p_duty_pair) else $error("duty high byte without low byte");

    property p_preset_zero;
        @(posedge ref_clk) disable iff (!arst_n)
        (dev_wr && dev_addr == tcx_pkg::TCX_ADDR_CTRL_HIGH && dev_wdata[1:0] != tcx_pkg::TCX_MODE_PWM)
            |-> !dev_wdata[tcx_pkg::TCX_PRESET_BIT];
    endproperty
    a_preset_zero: assert property (p_preset_zero) else $error("preset set outside pwm");

    property p_period_stopped;
        @(posedge ref_clk) disable iff (!arst_n)
        (dev_wr && dev_addr == tcx_pkg::TCX_ADDR_PERIOD_LO) |-> !run_r;
    endproperty
    a_period_stopped: assert property (p_period_stopped) else $error("period written while running");

    property p_stop_keeps_preset;
        @(posedge ref_clk) disable iff (!arst_n)
        (dev_wr && dev_addr == tcx_pkg::TCX_ADDR_CTRL_HIGH && !dev_wdata[tcx_pkg::TCX_RUN_BIT]
            && $past(state_r) != TCX_S_PRE) |-> (dev_wdata[tcx_pkg::TCX_PRESET_BIT] == $past(pre_r));
    endproperty
    a_stop_keeps_preset: assert property (p_stop_keeps_preset) else $error("preset changed with stop");

    property p_duty_after_irq;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_r == TCX_S_WAIT && irq_rise) |-> ##2 (dev_wr && dev_addr == tcx_pkg::TCX_ADDR_DUTY_LO) ##1
            (dev_wr && dev_addr == tcx_pkg::TCX_ADDR_DUTY_HI);
    endproperty
    a_duty_after_irq: assert property (p_duty_after_irq) else $error("duty not written right after irq");

    property p_clk_legal;
        @(posedge ref_clk) disable iff (!arst_n)
        (dev_wr && dev_addr == tcx_pkg::TCX_ADDR_CTRL_LOW && dev_wdata[1:0] != tcx_pkg::TCX_MODE_PWM)
            |-> (dev_wdata[6:4] <= tcx_pkg::TCX_CLK_DIV3);
    endproperty
    a_clk_legal: assert property (p_clk_legal) else $error("pwm-only clock in timer mode");

    property p_force_sequence;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_r == TCX_S_PRE && $past(state_r) == TCX_S_STOP) |=>
            (dev_wr && $past(dev_wr) && !dev_wdata[tcx_pkg::TCX_RUN_BIT]);
    endproperty
    a_force_sequence: assert property (p_force_sequence) else $error("preset not after stop write");

    property p_latch_pwm;
        @(posedge ref_clk) disable iff (!arst_n)
        (state_r == TCX_S_CFG && mode_r == tcx_pkg::TCX_MODE_PWM) |-> ##1 port_latch ##1 port_latch;
    endproperty
    a_latch_pwm: assert property (p_latch_pwm) else $error("port latch low in pwm");
endmodule

// ---- design/tcx_pkg.sv ----
// constants shared by the cascaded timer host controller and its event pulser
// assumes the device exposes byte registers on a 3-bit address write port
package tcx_pkg;
    // device register map, byte wide
    localparam logic [2:0] TCX_ADDR_PERIOD_LO = 3'h0;
    localparam logic [2:0] TCX_ADDR_PERIOD_HI = 3'h1;
    localparam logic [2:0] TCX_ADDR_DUTY_LO = 3'h2;
    localparam logic [2:0] TCX_ADDR_DUTY_HI = 3'h3;
    localparam logic [2:0] TCX_ADDR_CTRL_LOW = 3'h4;
    localparam logic [2:0] TCX_ADDR_CTRL_HIGH = 3'h5;
    // control field positions
    localparam int TCX_RUN_BIT = 3;
    localparam int TCX_PRESET_BIT = 7;
    localparam int TCX_CLK_LSB = 4;
    localparam logic [7:0] TCX_CTRL_RESET = 8'h00;
    // counter modes
    localparam logic [1:0] TCX_MODE_TIMER = 2'h0;
    localparam logic [1:0] TCX_MODE_EVENT = 2'h1;
    localparam logic [1:0] TCX_MODE_PWM = 2'h2;
    // source clock codes; codes 4..6 exist only for pwm
    localparam logic [2:0] TCX_CLK_SLOWEST = 3'h0;
    localparam logic [2:0] TCX_CLK_DIV7 = 3'h1;
    localparam logic [2:0] TCX_CLK_DIV5 = 3'h2;
    localparam logic [2:0] TCX_CLK_DIV3 = 3'h3;
    localparam logic [2:0] TCX_CLK_FS = 3'h4;
    localparam logic [2:0] TCX_CLK_FC_DIV2 = 3'h5;
    localparam logic [2:0] TCX_CLK_FC = 3'h6;
    // user commands
    localparam logic [2:0] TCX_OP_CONFIG = 3'h0;
    localparam logic [2:0] TCX_OP_PERIOD = 3'h1;
    localparam logic [2:0] TCX_OP_DUTY = 3'h2;
    localparam logic [2:0] TCX_OP_START = 3'h3;
    localparam logic [2:0] TCX_OP_STOP = 3'h4;
    localparam logic [2:0] TCX_OP_LEVEL = 3'h5;
    localparam logic [2:0] TCX_OP_PULSE = 3'h6;
    // timing: least phase of the count input, rounded up to ref_clk cycles
    localparam int TCX_REF_PERIOD_PS = 4000;
    localparam int TCX_EVT_PHASE_NS = 500;
    localparam int TCX_EVT_PHASE_CYC = (TCX_EVT_PHASE_NS * 1000 + TCX_REF_PERIOD_PS - 1) / TCX_REF_PERIOD_PS;
    localparam logic [6:0] TCX_EVT_PHASE_LAST = 7'(TCX_EVT_PHASE_CYC - 1);
endpackage

// ---- testbench/tcx_dev_model.sv ----
// behavioural timer device: byte registers, cascaded counter, pwm flip-flop
// assumes one-cycle byte writes on dev_addr/dev_wdata/dev_wr, all on ref_clk
module tcx_dev_model #(
    parameter logic [15:0] OVF_TOP = 16'h003F
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [2:0] dev_addr,
    input wire logic [7:0] dev_wdata,
    input wire logic dev_wr,
    input wire logic event_count_input,
    output logic match_overflow_irq,
    output logic pwm_out_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cmp, duty, dbuf, cnt;
    logic [7:0] ctl_lo, ctl_hi, lo_b, ph;
    logic [2:0] pre, hold;
    logic plo, pdl, dpend, ff, evq, tick;
    int fault_count;
    wire logic run = ctl_hi[3];
    wire logic pwm = (ctl_lo[1:0] == tcx_pkg::TCX_MODE_PWM);
    wire logic evm = (ctl_lo[1:0] == tcx_pkg::TCX_MODE_EVENT);
    // overflow top shortened; the real pair wraps at all ones
    wire logic [2:0] div = (ctl_lo[6:4] == 3'h6) ? 3'h1 : ctl_lo[6:4] + 3'h2;
    wire logic ovf = tick && pwm && cnt == OVF_TOP;
    assign tick = run & (evm ? (evq & ~event_count_input) : (pre == div - 3'h1));
    assign pwm_out_pin = ~ff;
    assign match_overflow_irq = (hold != 3'h0);
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {cmp, duty, dbuf, cnt, ctl_lo, ctl_hi, lo_b, pre, hold} <= '0;
            {plo, pdl, dpend, ff} <= '0;
            evq <= 1'b1;
            ph <= 8'hFF;
            fault_count <= 0;
        end else begin
            evq <= event_count_input;
            pre <= (pre >= div - 3'h1) ? 3'h0 : pre + 3'h1;
            if (hold != 3'h0) hold <= hold - 3'h1;
            if (evq != event_count_input) begin
                if (ph < 8'(tcx_pkg::TCX_EVT_PHASE_CYC - 1)) fault_count <= fault_count + 1;
                ph <= 8'h00;
            end else if (ph != 8'hFF) ph <= ph + 8'h01;
            if (tick) begin
                if (pwm ? cnt == OVF_TOP : cnt == cmp) begin
                    cnt <= 16'h0000;
                    hold <= 3'h4;
                    if (pwm) ff <= ~ff;
                    if (dpend) duty <= dbuf;
                    dpend <= 1'b0;
                end else begin
                    cnt <= cnt + 16'h0001;
                    if (pwm && cnt == duty) ff <= ~ff;
                end
            end else if (!run) cnt <= 16'h0000;
            if (dev_wr) begin
                case (dev_addr)
                    tcx_pkg::TCX_ADDR_PERIOD_LO: begin
                        cmp[7:0] <= dev_wdata;
                        plo <= 1'b1;
                        if (run) fault_count <= fault_count + 1;
                    end
                    tcx_pkg::TCX_ADDR_PERIOD_HI: begin
                        cmp[15:8] <= dev_wdata;
                        plo <= 1'b0;
                        if (!plo) fault_count <= fault_count + 1;
                    end
                    tcx_pkg::TCX_ADDR_DUTY_LO: begin
                        lo_b <= dev_wdata;
                        pdl <= 1'b1;
                    end
                    tcx_pkg::TCX_ADDR_DUTY_HI: begin
                        pdl <= 1'b0;
                        if (!pdl || ovf) fault_count <= fault_count + 1;
                        if (run && pwm) begin
                            dbuf <= {dev_wdata, lo_b};
                            dpend <= 1'b1;
                        end else duty <= {dev_wdata, lo_b};
                    end
                    tcx_pkg::TCX_ADDR_CTRL_LOW: ctl_lo <= dev_wdata;
                    tcx_pkg::TCX_ADDR_CTRL_HIGH: begin
                        ctl_hi <= dev_wdata;
                        // preset zero outside pwm, and a stop write while running must keep the preset bit unchanged
                        if ((!pwm && dev_wdata[7]) || (run && !dev_wdata[3] && dev_wdata[7] != ctl_hi[7]))
                            fault_count <= fault_count + 1;
                        if (!run) ff <= dev_wdata[7];
                    end
                    default: fault_count <= fault_count + 1;
                endcase
            end
        end
    end
endmodule

// ---- testbench/tcx_host_tb.sv ----
// self-checking bench: host controller driving the device model
// assumes the model's internal state may be probed by hierarchy
module tcx_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] TOP = 16'h003F;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [15:0] cmd_data = 16'h0000;
    logic slow_mode = 1'b0;
    logic cmd_ready, irq_event, pwm_level, dev_wr, divider7_clock_select, port_latch;
    logic event_count_input, match_overflow_irq, pwm_out_pin, lvl;
    logic [2:0] dev_addr;
    logic [7:0] dev_wdata;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int toggles = 0;
    int irqs = 0;
    int n, t0;
    always #2 ref_clk = ~ref_clk;
    tcx_host uut (.ref_clk, .arst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_data, .slow_mode, .irq_event,
        .pwm_level, .dev_addr, .dev_wdata, .dev_wr, .divider7_clock_select, .port_latch, .event_count_input,
        .match_overflow_irq, .pwm_out_pin);
    tcx_dev_model #(.OVF_TOP(TOP)) dev (.ref_clk, .arst_n, .dev_addr, .dev_wdata, .dev_wr,
        .event_count_input, .match_overflow_irq, .pwm_out_pin);
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic cmd(input logic [2:0] op, input logic [15:0] data);
        @(posedge ref_clk);
        #1;
        while (cmd_ready !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_data = data;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        do begin
            @(posedge ref_clk);
            #1;
        end while (cmd_ready !== 1'b1);
        // last device write still stands as ready returns
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_irq(output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (irq_event !== 1'b1 && k < 3000);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (irq_event === 1'b1) irqs++;
        if (pwm_level !== lvl) toggles++;
        lvl = pwm_level;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        chk_bit(dev.ff, 1'b0);
        chk_bit(event_count_input, 1'b1);
        #1;
        arst_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        chk_bit(pwm_level, 1'b1);
        $display("test reset done");
        cmd(tcx_pkg::TCX_OP_CONFIG, 16'h002C);
        chk_word({8'h00, dev.ctl_lo}, 16'h0030);
        chk_word({8'h00, dev.ctl_hi}, 16'h0000);
        cmd(tcx_pkg::TCX_OP_PERIOD, 16'h0005);
        chk_word(dev.cmp, 16'h0005);
        cmd(tcx_pkg::TCX_OP_START, 16'h0000);
        wait_irq(n);
        wait_irq(n);
        chk_word(16'(n), 16'h001E);
        cmd(tcx_pkg::TCX_OP_PERIOD, 16'h0102);
        wait_irq(n);
        wait_irq(n);
        chk_word(16'(n), 16'h050F);
        cmd(tcx_pkg::TCX_OP_STOP, 16'h0000);
        $display("test timer done");
        cmd(tcx_pkg::TCX_OP_CONFIG, 16'h001C);
        chk_word({8'h00, dev.ctl_lo}, 16'h0000);
        slow_mode = 1'b1;
        cmd(tcx_pkg::TCX_OP_CONFIG, 16'h000C);
        chk_word({8'h00, dev.ctl_lo}, 16'h0000);
        chk_bit(divider7_clock_select, 1'b1);
        cmd(tcx_pkg::TCX_OP_CONFIG, 16'h0012);
        chk_word({8'h00, dev.ctl_lo}, 16'h0042);
        slow_mode = 1'b0;
        $display("test clocks done");
        cmd(tcx_pkg::TCX_OP_CONFIG, 16'h0001);
        cmd(tcx_pkg::TCX_OP_PERIOD, 16'h0001);
        cmd(tcx_pkg::TCX_OP_START, 16'h0000);
        t0 = irqs;
        cmd(tcx_pkg::TCX_OP_PULSE, 16'h0000);
        chk_word(dev.cnt, 16'h0001);
        cmd(tcx_pkg::TCX_OP_PULSE, 16'h0000);
        repeat (8) @(posedge ref_clk);
        chk_word(16'(irqs - t0), 16'h0001);
        chk_word(dev.cnt, 16'h0000);
        cmd(tcx_pkg::TCX_OP_STOP, 16'h0000);
        $display("test event done");
        cmd(tcx_pkg::TCX_OP_CONFIG, 16'h001A);
        chk_bit(port_latch, 1'b1);
        chk_word({8'h00, dev.ctl_lo}, 16'h0062);
        cmd(tcx_pkg::TCX_OP_DUTY, 16'h0010);
        chk_word(dev.duty, 16'h0010);
        cmd(tcx_pkg::TCX_OP_START, 16'h0000);
        wait_irq(n);
        t0 = toggles;
        wait_irq(n);
        chk_word(16'(n), TOP + 16'h0001);
        chk_word(16'(toggles - t0), 16'h0002);
        cmd(tcx_pkg::TCX_OP_DUTY, 16'h0020);
        chk_word(dev.duty, 16'h0010);
        wait_irq(n);
        chk_word(dev.duty, 16'h0020);
        cmd(tcx_pkg::TCX_OP_STOP, 16'h0000);
        repeat (8) @(posedge ref_clk);
        t0 = toggles;
        repeat (130) @(posedge ref_clk);
        chk_word(16'(toggles - t0), 16'h0000);
        cmd(tcx_pkg::TCX_OP_LEVEL, 16'h0000);
        repeat (8) @(posedge ref_clk);
        chk_bit(pwm_level, 1'b1);
        cmd(tcx_pkg::TCX_OP_LEVEL, 16'h0001);
        repeat (8) @(posedge ref_clk);
        chk_bit(pwm_level, 1'b0);
        cmd(tcx_pkg::TCX_OP_START, 16'h0000);
        wait_irq(n);
        cmd(tcx_pkg::TCX_OP_LEVEL, 16'h0000);
        repeat (8) @(posedge ref_clk);
        chk_bit(pwm_level, 1'b1);
        chk_word(16'(dev.fault_count), 16'h0000);
        $display("test pwm done");
        complete_run();
    end
endmodule
